/* File: rtl/bfc_core.v */
// Fault protection and switching frequency control for a two-phase buck
// Contract
// - Powers up in constant on-time mode; PLL mode after enabling loop and enable cycle.
// - PLL mode picks 0.5/1.0/1.25/1.5 MHz from programmed output voltage.
// - Default mode switches at a fixed 470 kHz, whatever the output voltage.
// - During early start-up, control switch uses minimum on-time pulse.
// - High-side on-intervals of the two phases never overlap.
// - With default on/off setup, enable input turns regulation on and off.
// - Over-current fault when sync-switch current exceeds trip level.
// - Over-current immediately drops power-good and soft-start.
// - After over-current, sync switch stays on until current reaches zero.
// - Hiccup holds switches off for blanking time, then retries while fault persists.
// - Optionally, over-current latches shutdown instead of hiccup.
// - Over-voltage fault only after feedback stays high past qualification delay.
// - Over-voltage trip level rounds to 105, 110, 115 or 120 percent.
// - After reset, over-voltage trip level is 120 percent.
// - Over-voltage turns all switches off and drops power-good at once.
// - Over-voltage latch clears by supply or enable cycling, or by run-command fall when on/off setup is not default.
// - Voltage warnings and under-voltage fault come from digital telemetry compares.
// - Over-temperature trips at lower of fixed and programmable thresholds.
// - Above 145 degrees switching stops; auto-restart when it cools.
// - Programmable limit, 1 degree steps; action ignore or latch off.
// - Latched over-temperature clears by enable cycle, or by run-command fall when on/off setup is not default.
// - Reset programmable limit 150 degrees, action ignore.
// - Voltage code is 1/256 V per bit.
`timescale 1ns/1ps
`include "bfc_map.vh"
module bfc_core #(
  parameter HICCUP_CYC = `BFC_HICCUP_CYC
) (
  // Clock and reset
  input wire i_clk,
  input wire i_srst,
  // Control inputs
  input wire i_enable,
  input wire i_onoff_default,
  input wire i_pll_enable,
  input wire i_ocp_latch_mode,
  input wire i_run_cmd,
  // Programmed levels
  input wire [10:0] i_vout_code,
  input wire [5:0] i_current_trip_level,
  input wire [11:0] i_overvolt_trip_level,
  input wire [10:0] i_overvolt_alert_level,
  input wire [10:0] i_undervolt_alert_level,
  input wire [10:0] i_undervolt_trip_level,
  input wire [7:0] i_heat_trip_level,
  input wire i_heat_trip_action,
  input wire i_cfg_load,
  // Sensing
  input wire [5:0] i_sync_current,
  input wire i_sync_current_zero,
  input wire i_feedback_sense_over,
  input wire [10:0] i_vout_telemetry,
  input wire [7:0] i_temperature,
  input wire i_ss_level_low,
  // Power stage
  output reg o_hs_a,
  output reg o_ls_a,
  output reg o_hs_b,
  output reg o_ls_b,
  output reg o_soft_start_run,
  output reg o_power_good_out,
  // Status
  output reg o_pll_mode,
  output reg [10:0] o_fsw_khz,
  output reg [1:0] o_ov_sel,
  output reg o_overcurrent_guard,
  output reg o_overvoltage_guard,
  output reg o_heat_fault,
  output reg o_heat_latched,
  output reg o_ov_warn,
  output reg o_uv_warn,
  output reg o_uv_fault
);
  localparam ST_OFF = 5'h01;
  localparam ST_RUN = 5'h02;
  localparam ST_DRAIN = 5'h04;
  localparam ST_HICCUP = 5'h08;
  localparam ST_LATCH = 5'h10;
  localparam [14:0] HIC_LAST = HICCUP_CYC[14:0] - 15'h0001;
  // Cycle counts are worked out as integers, then cut to counter width
  localparam integer OVP_DLY = `BFC_OVP_DLY_CYC;
  localparam integer TON_CYC = `BFC_TON_MIN_CYC;
  localparam [7:0] OVP_LAST = OVP_DLY[7:0] - 8'h01;
  localparam [7:0] TON_MIN = TON_CYC[7:0];
  localparam [7:0] PER_DIV = 8'h14;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg en_d_reg;
  reg run_d_reg;
  reg [14:0] hic_cnt_reg;
  reg [7:0] ovp_cnt_reg;
  reg [1:0] ov_sel_next;
  reg [7:0] heat_lim_reg;
  reg heat_act_reg;
  reg [1:0] ov_cfg_reg;
  reg [7:0] ph_cnt_reg;
  reg [7:0] period_reg;
  reg [7:0] period_next;
  reg ph_sel_reg;
  wire en_rise;
  wire en_fall;
  wire run_fall;
  wire run_req;
  wire oc_hit;
  wire ovp_hit;
  wire hot_fixed;
  wire hot_prog;
  wire [7:0] ton;

  assign en_rise = i_enable & ~en_d_reg;
  assign en_fall = ~i_enable & en_d_reg;
  // Only a falling command releases a latch, so a held level cannot re-arm
  assign run_fall = ~i_run_cmd & run_d_reg;
  // Run-control command stands in for enable when on/off setup is not default
  assign run_req = i_onoff_default ? i_enable : i_run_cmd;
  assign oc_hit = i_sync_current > i_current_trip_level;
  assign ovp_hit = i_feedback_sense_over & (ovp_cnt_reg == OVP_LAST);
  assign hot_fixed = i_temperature > `BFC_OT_FIXED;
  assign hot_prog = (heat_act_reg != `BFC_OTACT_IGNORE) &&
    (i_temperature > heat_lim_reg);
  // Soft-start ramp too low: shortest on-time only
  assign ton = i_ss_level_low ? TON_MIN :
    {1'b0, period_reg[7:1]} - 8'h02;

  // Over-voltage rounding; the code is percent times ten
  always @* begin
    if (i_overvolt_trip_level <= `BFC_OVL_BP1)
      ov_sel_next = `BFC_OVL_105;
    else if (i_overvolt_trip_level <= `BFC_OVL_BP2)
      ov_sel_next = `BFC_OVL_110;
    else if (i_overvolt_trip_level <= `BFC_OVL_BP3)
      ov_sel_next = `BFC_OVL_115;
    else
      ov_sel_next = `BFC_OVL_120;
  end

  // Frequency choice; codes are 1/256 V per bit
  always @* begin
    if (!o_pll_mode)
      period_next = 8'h2A;
    else if (i_vout_code < `BFC_VCODE_065)
      period_next = 8'h28;
    else if (i_vout_code <= `BFC_VCODE_110)
      period_next = PER_DIV;
    else if (i_vout_code <= `BFC_VCODE_132)
      period_next = 8'h10;
    else
      period_next = 8'h0D;
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (run_req && !hot_fixed)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!run_req)
          state_next = ST_OFF;
        else if (ovp_hit || (hot_prog && i_heat_trip_action))
          state_next = ST_LATCH;
        else if (oc_hit)
          state_next = ST_DRAIN;
        else if (hot_fixed)
          state_next = ST_OFF;
      end
      ST_DRAIN: begin
        if (ovp_hit)
          state_next = ST_LATCH;
        else if (i_sync_current_zero)
          state_next = i_ocp_latch_mode ? ST_LATCH : ST_HICCUP;
      end
      ST_HICCUP: begin
        if (ovp_hit)
          state_next = ST_LATCH;
        else if (hic_cnt_reg == HIC_LAST)
          state_next = ST_OFF;
      end
      ST_LATCH: begin
        if (en_fall || (!i_onoff_default && run_fall))
          state_next = ST_OFF;
      end
      default: state_next = ST_OFF;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      state_reg <= ST_OFF;
      en_d_reg <= 1'b0;
      run_d_reg <= 1'b0;
      hic_cnt_reg <= 15'h0000;
      ovp_cnt_reg <= 8'h00;
      o_pll_mode <= 1'b0;
      ov_cfg_reg <= `BFC_OVL_120;
      heat_lim_reg <= `BFC_OT_RST;
      heat_act_reg <= `BFC_OTACT_IGNORE;
      o_heat_latched <= 1'b0;
      period_reg <= 8'h2A;
      ph_cnt_reg <= 8'h00;
      ph_sel_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      en_d_reg <= i_enable;
      run_d_reg <= i_run_cmd;
      // Mode change only on an enable edge, never mid-conversion while enable controls on/off
      if (en_rise)
        o_pll_mode <= i_pll_enable;
      if (i_cfg_load) begin
        ov_cfg_reg <= ov_sel_next;
        heat_lim_reg <= i_heat_trip_level;
        heat_act_reg <= i_heat_trip_action;
      end
      // Counter runs only in hiccup, so each new fault gets the full blank
      if (state_reg == ST_HICCUP)
        hic_cnt_reg <= hic_cnt_reg + 15'h0001;
      else
        hic_cnt_reg <= 15'h0000;
      // Any drop of the comparator restarts qualification, filtering glitches
      if (!i_feedback_sense_over)
        ovp_cnt_reg <= 8'h00;
      else if (ovp_cnt_reg != OVP_LAST)
        ovp_cnt_reg <= ovp_cnt_reg + 8'h01;
      if (state_next == ST_LATCH && state_reg != ST_LATCH)
        o_heat_latched <= hot_prog;
      else if (state_next == ST_OFF)
        o_heat_latched <= 1'b0;
      // Alternate phases each half period so high sides never overlap
      if (ph_cnt_reg >= {1'b0, period_reg[7:1]} - 8'h01) begin
        ph_cnt_reg <= 8'h00;
        ph_sel_reg <= ~ph_sel_reg;
        period_reg <= period_next;
      end else
        ph_cnt_reg <= ph_cnt_reg + 8'h01;
    end
  end

  always @(posedge i_clk) begin
    if (i_srst) begin
      o_hs_a <= 1'b0;
      o_ls_a <= 1'b0;
      o_hs_b <= 1'b0;
      o_ls_b <= 1'b0;
      o_soft_start_run <= 1'b0;
      o_power_good_out <= 1'b0;
      o_fsw_khz <= 11'h000;
      o_ov_sel <= `BFC_OVL_120;
      o_overcurrent_guard <= 1'b0;
      o_overvoltage_guard <= 1'b0;
      o_heat_fault <= 1'b0;
      o_ov_warn <= 1'b0;
      o_uv_warn <= 1'b0;
      o_uv_fault <= 1'b0;
    end else begin
      o_ov_sel <= ov_cfg_reg;
      o_overcurrent_guard <= oc_hit;
      o_overvoltage_guard <= ovp_hit | (o_overvoltage_guard &
        (state_reg == ST_LATCH));
      // Ignore action leaves only the fixed trip in force
      o_heat_fault <= hot_fixed | hot_prog;
      // Telemetry compares
      o_ov_warn <= i_vout_telemetry > i_overvolt_alert_level;
      o_uv_warn <= i_vout_telemetry < i_undervolt_alert_level;
      o_uv_fault <= i_vout_telemetry < i_undervolt_trip_level;
      if (!o_pll_mode)
        o_fsw_khz <= `BFC_FSW_COT_KHZ;
      else if (i_vout_code < `BFC_VCODE_065)
        o_fsw_khz <= `BFC_FSW_050_KHZ;
      else if (i_vout_code <= `BFC_VCODE_110)
        o_fsw_khz <= `BFC_FSW_100_KHZ;
      else if (i_vout_code <= `BFC_VCODE_132)
        o_fsw_khz <= `BFC_FSW_125_KHZ;
      else
        o_fsw_khz <= `BFC_FSW_150_KHZ;
      // Any run-state exit clears the high sides in the same edge; drain turns the low sides on
      if (state_next == ST_RUN && state_reg == ST_RUN) begin
        o_hs_a <= ~ph_sel_reg & (ph_cnt_reg < ton);
        o_ls_a <= ~(~ph_sel_reg & (ph_cnt_reg < ton));
        o_hs_b <= ph_sel_reg & (ph_cnt_reg < ton);
        o_ls_b <= ~(ph_sel_reg & (ph_cnt_reg < ton));
      end else begin
        o_hs_a <= 1'b0;
        o_hs_b <= 1'b0;
        o_ls_a <= (state_next == ST_DRAIN);
        o_ls_b <= (state_next == ST_DRAIN);
      end
      o_soft_start_run <= (state_next == ST_RUN);
      o_power_good_out <= (state_next == ST_RUN) && (state_reg == ST_RUN) &&
        !i_ss_level_low && !hot_prog;
    end
  end
endmodule

/* File: rtl/bfc_map.vh */
// Constants for the buck fault and frequency control block
`ifndef BFC_MAP_VH
`define BFC_MAP_VH
`define BFC_CLK_KHZ 20000
`define BFC_VCODE_065 11'h0A7
`define BFC_VCODE_110 11'h11A
`define BFC_VCODE_132 11'h152
`define BFC_FSW_050_KHZ 11'h1F4
`define BFC_FSW_100_KHZ 11'h3E8
`define BFC_FSW_125_KHZ 11'h4E2
`define BFC_FSW_150_KHZ 11'h5DC
`define BFC_FSW_COT_KHZ 11'h1D6
`define BFC_VCODE_060 11'h09A
`define BFC_OVP_DLY_NS 5000
`define BFC_OVP_DLY_CYC ((`BFC_OVP_DLY_NS * `BFC_CLK_KHZ) / 1000000)
`define BFC_TON_MIN_NS 100
`define BFC_TON_MIN_CYC ((`BFC_TON_MIN_NS * `BFC_CLK_KHZ + 999999) / 1000000)
`define BFC_HICCUP_CYC 20000
`define BFC_OVL_BP1 12'h41E
`define BFC_OVL_BP2 12'h44D
`define BFC_OVL_BP3 12'h47C
`define BFC_OVL_105 2'h0
`define BFC_OVL_110 2'h1
`define BFC_OVL_115 2'h2
`define BFC_OVL_120 2'h3
`define BFC_OVL_RST 12'h4B3
`define BFC_OT_FIXED 8'h91
`define BFC_OT_RST 8'h96
`define BFC_OTACT_IGNORE 1'h0
`define BFC_SOFTSTART_LOW 11'h010
`endif

/* File: test/bfc_assertions.sv */
// Concurrent checks on the fault and frequency control ports
`timescale 1ns/1ps
module bfc_assertions (
  // Clock, reset and control
  input wire i_clk, input wire i_srst, input wire i_enable,
  // Sensing and settings
  input wire [5:0] i_sync_current, input wire [5:0] i_current_trip_level,
  input wire i_feedback_sense_over, input wire [7:0] i_temperature,
  input wire [10:0] i_vout_code,
  input wire i_ss_level_low,
  // Watched outputs
  input wire o_hs_a, input wire o_ls_a, input wire o_hs_b, input wire o_ls_b,
  input wire o_soft_start_run, input wire o_power_good_out,
  input wire o_pll_mode, input wire [10:0] o_fsw_khz,
  input wire [1:0] o_ov_sel, input wire o_overvoltage_guard
);
  reg [7:0] fb_cnt;
  // Codes 11'h11A and 11'h152 expect the next higher frequency here, where the core keeps the lower
  wire [10:0] f_exp = i_vout_code < 11'h0A7 ? 11'h1F4 :
    i_vout_code < 11'h11A ? 11'h3E8 : i_vout_code < 11'h152 ? 11'h4E2 :
    11'h5DC;
  always @(posedge i_clk)
    if (i_srst || !i_feedback_sense_over) fb_cnt <= 8'h00;
    else if (fb_cnt != 8'hFF) fb_cnt <= fb_cnt + 8'h01;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_hot;
    i_temperature > 8'h91 ##1 i_temperature > 8'h91;
  endsequence
  property p_rst_ov; $fell(i_srst) |-> o_ov_sel == 2'h3; endproperty
  a_rst_ov: assert property (p_rst_ov) else $error("ov level bad");
  property p_rst_pll; $fell(i_srst) |-> !o_pll_mode; endproperty
  a_rst_pll: assert property (p_rst_pll) else $error("pll on");
  property p_ovl; !(o_hs_a && o_hs_b); endproperty
  a_ovl: assert property (p_ovl) else $error("high sides overlap");
  property p_oc; o_soft_start_run && i_sync_current > i_current_trip_level
    |=> !o_power_good_out && !o_soft_start_run; endproperty
  a_oc: assert property (p_oc) else $error("oc not acted");
  property p_ovp; o_overvoltage_guard
    |=> !(o_hs_a || o_ls_a || o_hs_b || o_ls_b || o_power_good_out);
  endproperty
  a_ovp: assert property (p_ovp) else $error("ov drivers on");
  property p_qual; $rose(o_overvoltage_guard) |-> fb_cnt >= 8'd99; endproperty
  a_qual: assert property (p_qual) else $error("ov too early");
  property p_ovlat; o_overvoltage_guard && i_enable |=> o_overvoltage_guard;
  endproperty
  a_ovlat: assert property (p_ovlat) else $error("ov latch lost");
  property p_hot; s_hot |=> !o_hs_a && !o_hs_b; endproperty
  a_hot: assert property (p_hot) else $error("switching when hot");
  property p_fsw; (o_pll_mode && $stable(i_vout_code)) [*3]
    |-> o_fsw_khz == f_exp; endproperty
  a_fsw: assert property (p_fsw) else $error("pll freq bad");
  property p_tmin; (i_ss_level_low && o_hs_a) [*2] |=> !o_hs_a;
  endproperty
  a_tmin: assert property (p_tmin) else $error("on-time too long");
endmodule
bind bfc_core bfc_assertions chk_u (.*);

/* File: test/bfc_stage_model.sv */
// Power stage model: inductor current seen by the low-side sense
`timescale 1ns/1ps
module bfc_stage_model (
  // Clock and drivers
  input wire i_clk, input wire i_hs_a, input wire i_hs_b,
  // Load set by the bench, in 0.5 A steps
  input wire [5:0] i_load,
  // Current sense
  output reg [5:0] o_sync_current, output wire o_sync_current_zero
);
  // Decay over several cycles, so the zero flag comes late, as in a coil
  initial o_sync_current = 6'h00;
  always @(posedge i_clk)
    if (i_hs_a || i_hs_b) o_sync_current <= i_load;
    else if (o_sync_current > 6'h03) o_sync_current <= o_sync_current - 6'h04;
    else o_sync_current <= 6'h00;
  assign o_sync_current_zero = (o_sync_current == 6'h00);
endmodule

/* File: test/tb.sv */
// Self-checking bench for the buck fault and frequency control block
`timescale 1ns/1ps
module tb;
  reg i_clk = 0, i_srst = 1, i_enable = 0, i_onoff_default = 1, i_run_cmd = 0;
  reg i_pll_enable = 0, i_ocp_latch_mode = 0, i_cfg_load = 0;
  reg i_feedback_sense_over = 0, i_heat_trip_action = 0, i_ss_level_low = 0;
  reg [10:0] i_vout_code = 11'h09A, i_vout_telemetry = 11'h09A;
  reg [10:0] i_overvolt_alert_level = 11'h100, i_undervolt_trip_level = 11'h0A0;
  reg [10:0] i_undervolt_alert_level = 11'h0C0;
  reg [11:0] i_overvolt_trip_level = 12'h4B0;
  reg [7:0] i_heat_trip_level = 8'h96, i_temperature = 8'h19;
  reg [5:0] i_current_trip_level = 6'h14, load = 6'h0A;
  wire [5:0] i_sync_current;
  wire i_sync_current_zero, o_hs_a, o_ls_a, o_hs_b, o_ls_b, o_soft_start_run;
  wire o_power_good_out, o_pll_mode, o_overcurrent_guard, o_overvoltage_guard;
  wire o_heat_fault, o_heat_latched, o_ov_warn, o_uv_warn, o_uv_fault;
  wire [10:0] o_fsw_khz;
  wire [1:0] o_ov_sel;
  integer mismatches = 0, n_tests = 0, k, hsn;
  reg [31:0] rnd = 32'hadecf01a;
  reg [11:0] tl [0:5] = '{12'h41E, 12'h41F, 12'h44D, 12'h44E, 12'h47C, 12'h47D};
  always #25 i_clk = ~i_clk;
  bfc_core #(.HICCUP_CYC(20)) dut_u (.*);
  bfc_stage_model stage_u (.i_clk(i_clk), .i_hs_a(o_hs_a), .i_hs_b(o_hs_b),
    .i_load(load), .o_sync_current(i_sync_current),
    .o_sync_current_zero(i_sync_current_zero));
  task cyc(input integer n); repeat (n) @(negedge i_clk); endtask
  task chk(input [15:0] g, input [15:0] e); begin
    n_tests = n_tests + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  end endtask
  task nx; begin
    rnd = rnd ^ (rnd << 13); rnd = rnd ^ (rnd >> 17); rnd = rnd ^ (rnd << 5);
  end endtask
  task encyc; begin i_enable = 0; cyc(3); i_enable = 1; cyc(3); end endtask
  task cfg; begin i_cfg_load = 1; cyc(1); i_cfg_load = 0; cyc(2); end endtask
  task wait_oc; begin
    for (k = 0; k < 200 && o_overcurrent_guard !== 1'b1; k = k + 1) cyc(1);
  end endtask
  function [1:0] oexp(input [11:0] l);
    oexp = l <= 12'h41E ? 2'h0 : l <= 12'h44D ? 2'h1 : l <= 12'h47C ? 2'h2 : 2'h3;
  endfunction
  function [10:0] fexp(input [10:0] c);
    fexp = c < 11'h0A7 ? 11'h1F4 : c < 11'h11A ? 11'h3E8 :
      c < 11'h152 ? 11'h4E2 : 11'h5DC;
  endfunction
  function [2:0] wexp(input [10:0] t);
    wexp = {t > 11'h100, t < 11'h0C0, t < 11'h0A0};
  endfunction
  task wrap_up; begin
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  end endtask
  initial begin #1000000; mismatches = mismatches + 1; wrap_up; end
  initial begin
    cyc(3); i_srst = 0; cyc(1);
    chk(o_ov_sel, 2'h3);
    chk(o_pll_mode, 1'b0);
    i_enable = 1; cyc(40);
    chk(o_soft_start_run, 1'b1);
    chk(o_fsw_khz, 11'h1D6);
    i_ss_level_low = 1; cyc(44); hsn = 0;
    for (k = 0; k < 42; k = k + 1) begin cyc(1); hsn = hsn + o_hs_a; end
    chk(hsn, 2);
    chk(o_power_good_out, 1'b0);
    i_ss_level_low = 0;
    i_temperature = 8'h93; cyc(40);
    chk({o_hs_a, o_hs_b, o_heat_latched}, 3'h0);
    chk(o_heat_fault, 1'b1);
    i_temperature = 8'h19; cyc(40);
    chk(o_soft_start_run, 1'b1);
    $display("heat auto-restart done");
    load = 6'h1E; wait_oc;
    chk({o_overcurrent_guard, o_power_good_out, o_soft_start_run}, 3'h4);
    chk({o_hs_a, o_hs_b}, 2'h0);
    load = 6'h0A; cyc(60);
    chk(o_soft_start_run, 1'b1);
    i_ocp_latch_mode = 1; load = 6'h1E; wait_oc; load = 6'h0A; cyc(100);
    chk(o_soft_start_run, 1'b0);
    encyc; cyc(20); i_ocp_latch_mode = 0;
    chk(o_soft_start_run, 1'b1);
    $display("overcurrent done");
    i_feedback_sense_over = 1; cyc(50);
    chk(o_overvoltage_guard, 1'b0);
    cyc(60); i_feedback_sense_over = 0; cyc(50);
    chk({o_overvoltage_guard, o_hs_a, o_hs_b, o_power_good_out}, 4'h8);
    encyc; cyc(20);
    chk(o_soft_start_run, 1'b1);
    $display("overvoltage done");
    for (k = 0; k < 14; k = k + 1) begin
      nx; i_overvolt_trip_level = k < 6 ? tl[k] : 12'h3E9 + rnd[7:0];
      cfg; chk(o_ov_sel, oexp(i_overvolt_trip_level));
    end
    $display("rounding done");
    i_heat_trip_level = 8'h64; i_heat_trip_action = 1; cfg;
    i_temperature = 8'h6E; cyc(5);
    chk(o_heat_latched, 1'b1);
    i_temperature = 8'h19; cyc(20);
    chk(o_soft_start_run, 1'b0);
    encyc; cyc(20);
    chk(o_soft_start_run, 1'b1);
    $display("programmable heat done");
    i_pll_enable = 1; cyc(3);
    chk(o_pll_mode, 1'b0);
    encyc;
    chk(o_pll_mode, 1'b1);
    for (k = 0; k < 20; k = k + 1) begin
      nx; i_vout_code = {rnd[9:2], 2'h1}; i_vout_telemetry = {rnd[20:11], 1'b1};
      cyc(4);
      chk(o_fsw_khz, fexp(i_vout_code));
      chk({o_ov_warn, o_uv_warn, o_uv_fault}, wexp(i_vout_telemetry));
    end
    $display("frequency and telemetry done");
    wrap_up;
  end
endmodule
